/* common/mcih_pkg.sv */
package mcih_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int REPLY_TIMEOUT_NS = 5000000;
  localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_NS / CLK_PERIOD_NS;
  // frame layout, bit positions counted from frame sync
  localparam logic [4:0] DATA_BITS = 5'h14;
  localparam logic [4:0] LAST_DATA_POS = 5'h13;
  localparam logic [4:0] LAST_FRAME_POS = 5'h17;
  localparam logic [19:0] DRIVE_FIXED_MASK = 20'h00FFF;
  localparam logic [19:0] DRIVE_MON_MASK = 20'hFF000;
  localparam logic [19:0] CHECK_MASK = 20'hFF040;
  // message codes
  localparam logic [3:0] SLAVE_ADDR_NIB = 4'hA;
  localparam logic [3:0] CMD_IDENT_NIB = 4'h0;
  localparam logic [3:0] CMD_PROG_NIB = 4'h1;
  localparam logic [7:0] HDR_WR_A = 8'h43;
  localparam logic [7:0] HDR_WR_B = 8'h47;
  localparam logic [7:0] HDR_RD_A = 8'h40;
  localparam logic [7:0] HDR_RD_B = 8'h44;
  localparam logic [7:0] IDENT_ADDR_BYTE = 8'hA0;
  localparam logic [7:0] READ_REPLY_ADDR = 8'hA1;
  localparam logic [1:0] IDENT_PREFIX = 2'h1;
  // arbitrary value, not a real part code
  localparam logic [5:0] DESIGN_CODE_DEFAULT = 6'h2A;
  localparam logic [1:0] AUX_PAD = 2'h3;
  localparam logic [1:0] END_FRAMES = 2'h2;
  localparam logic [1:0] REPLY_BYTES = 2'h2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [2:0] IDX_DATA = 3'h3;
  localparam int FIFO_DEPTH = 4;
  localparam int BYTE_W = 8;

  typedef struct packed {
    logic [7:0] mon;
    logic [3:0] l1;
    logic mr;
    logic mx;
    logic [5:0] aux;
  } mcih_frame_s;

  typedef enum logic [2:0] {TX_IDLE, TX_SEND, TX_GAP, TX_EOM1, TX_EOM2} mcih_tx_e;
  typedef enum logic [1:0] {CMD_NONE, CMD_IDENT, CMD_PROG} mcih_cmd_e;
endpackage

/* src/mcih_top.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module mcih_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_valid = count != '0;
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
      o_in_ready <= next_count != FULL;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mcih_top #(
  parameter int REPLY_TIMEOUT_CYC = mcih_pkg::REPLY_TIMEOUT_CYC,
  parameter logic [5:0] DESIGN_CODE = mcih_pkg::DESIGN_CODE_DEFAULT
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // serial bus pins
  input wire logic i_bit_clk,
  input wire logic i_fsync,
  input wire logic i_dd,
  input wire logic i_du,
  output logic o_du,
  output logic o_du_oe,
  // configuration strap
  input wire logic i_slave_strap,
  output logic o_slave_mode,
  // transmit byte stream
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // control channel control
  input wire logic i_tx_handshake_ctrl,
  input wire logic i_rx_handshake_ctrl,
  input wire logic i_ctl_chan_irq_enable,
  input wire logic i_rx_irq_enable,
  input wire logic i_reply_timeout_enable,
  // control channel status
  output logic [7:0] o_ctl_chan_rx_byte,
  output logic o_data_received_irq,
  output logic o_end_of_reception_irq,
  output logic o_data_acked_irq,
  output logic o_transfer_abort_irq,
  output logic o_tx_active_flag,
  // command/indication codes
  input wire logic [3:0] i_l1_code_tx,
  input wire logic [5:0] i_aux_code_tx,
  input wire logic i_aux_code_width_sel,
  output logic [3:0] o_l1_code_rx,
  output logic [5:0] o_aux_code_rx,
  output logic o_code_change_irq,
  output logic o_aux_change_irq,
  // slave register access
  output logic o_reg_wr,
  output logic [6:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  localparam int TW = $clog2(REPLY_TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(REPLY_TIMEOUT_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bit timing
  logic [1:0] bclk_sy;
  logic bclk_d;
  logic [1:0] fs_sy;
  logic [1:0] dd_sy;
  logic [1:0] du_sy;
  logic [1:0] strap_sy;
  logic [4:0] bit_pos;
  logic [19:0] rx_sh;
  logic fd;
  logic coll;
  wire rise = bclk_sy[1] && !bclk_d;
  wire [4:0] cur_pos = fs_sy[1] ? 5'h00 :
                       (bit_pos == mcih_pkg::LAST_FRAME_POS) ? bit_pos : bit_pos + 5'h01;
  wire [4:0] nxt_pos = (cur_pos == mcih_pkg::LAST_FRAME_POS) ? 5'h00 : cur_pos + 5'h01;
  wire cur_in = cur_pos < mcih_pkg::DATA_BITS;
  wire nxt_in = nxt_pos < mcih_pkg::DATA_BITS;
  wire [4:0] cur_idx = mcih_pkg::LAST_DATA_POS - cur_pos;
  wire [4:0] nxt_idx = mcih_pkg::LAST_DATA_POS - nxt_pos;
  mcih_pkg::mcih_frame_s rx_w;
  mcih_pkg::mcih_frame_s tx_w;
  logic [19:0] drive_mask;
  assign rx_w = rx_sh;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bclk_sy <= 2'h0;
      bclk_d <= 1'b0;
      fs_sy <= 2'h0;
      dd_sy <= 2'h3;
      du_sy <= 2'h3;
      strap_sy <= 2'h0;
    end
    else
    begin
      bclk_sy <= {bclk_sy[0], i_bit_clk};
      bclk_d <= bclk_sy[1];
      fs_sy <= {fs_sy[0], i_fsync};
      dd_sy <= {dd_sy[0], i_dd};
      du_sy <= {du_sy[0], i_du};
      strap_sy <= {strap_sy[0], i_slave_strap};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bit_pos <= mcih_pkg::LAST_FRAME_POS;
      rx_sh <= 20'hFFFFF;
      fd <= 1'b0;
      o_du <= 1'b1;
      o_du_oe <= 1'b0;
      coll <= 1'b0;
    end
    else
    begin
      fd <= rise && (cur_pos == mcih_pkg::LAST_DATA_POS);
      if (rise)
      begin
        bit_pos <= cur_pos;
        if (cur_in)
          rx_sh <= {rx_sh[18:0], dd_sy[1]};
        if (cur_in && o_du_oe && mcih_pkg::CHECK_MASK[cur_idx] && du_sy[1] != o_du)
          coll <= 1'b1;
        o_du <= nxt_in ? tx_w[nxt_idx] : 1'b1;
        o_du_oe <= nxt_in && drive_mask[nxt_idx];
      end
      else if (fd)
        coll <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode strap, sampled for three clocks after reset release, then held
  logic [1:0] strap_cnt;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      strap_cnt <= 2'h0;
      o_slave_mode <= 1'b0;
    end
    else if (strap_cnt != mcih_pkg::STRAP_WAIT)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      o_slave_mode <= strap_sy[1];
    end
  end
  wire slave = o_slave_mode;

  //////////////////////////////////////////////////////////////////////////////
  // receive side of the control channel
  logic prev_mx;
  logic [7:0] prev_mon;
  logic pend;
  logic rx_act;
  logic ack_gap;
  logic [1:0] mx_hi;
  logic [1:0] ab_cnt;
  logic [2:0] rx_idx;
  wire rx_ctrl = slave || i_rx_handshake_ctrl;
  wire mx_fall = prev_mx && !rx_w.mx;
  wire rx_err = fd && mx_fall && pend;
  wire rx_end = fd && rx_w.mx && mx_hi == (mcih_pkg::END_FRAMES - 2'h1) && (rx_act || pend);
  wire acc = fd && pend && !rx_w.mx && !prev_mx && rx_w.mon == prev_mon
             && (!rx_act || rx_ctrl);
  wire mr_out = !(rx_act && rx_ctrl && !ack_gap && ab_cnt == 2'h0);

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      prev_mx <= 1'b1;
      prev_mon <= 8'hFF;
      pend <= 1'b0;
      rx_act <= 1'b0;
      ack_gap <= 1'b0;
      mx_hi <= 2'h0;
      ab_cnt <= 2'h0;
      rx_idx <= 3'h0;
    end
    else if (fd)
    begin
      prev_mx <= rx_w.mx;
      prev_mon <= rx_w.mon;
      mx_hi <= !rx_w.mx ? 2'h0 : (mx_hi == mcih_pkg::END_FRAMES) ? mx_hi : mx_hi + 2'h1;
      pend <= (rx_err || rx_end) ? 1'b0 : mx_fall ? 1'b1 : acc ? 1'b0 : pend;
      rx_act <= (rx_err || rx_end) ? 1'b0 : acc ? 1'b1 : rx_act;
      ack_gap <= acc && rx_act;
      ab_cnt <= rx_err ? mcih_pkg::END_FRAMES : (ab_cnt != 2'h0) ? ab_cnt - 2'h1 : 2'h0;
      rx_idx <= (rx_err || rx_end) ? 3'h0 :
                (acc && rx_idx != mcih_pkg::IDX_DATA) ? rx_idx + 3'h1 : rx_idx;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ctl_chan_rx_byte <= 8'h00;
      o_data_received_irq <= 1'b0;
      o_end_of_reception_irq <= 1'b0;
    end
    else
    begin
      if (acc)
        o_ctl_chan_rx_byte <= rx_w.mon;
      o_data_received_irq <= acc && i_rx_irq_enable;
      o_end_of_reception_irq <= (rx_end || rx_err) && i_ctl_chan_irq_enable;
    end
  end

  a_rx_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_data_received_irq |-> $past(i_rx_irq_enable) && $past(acc))
    else $error("data received flagged while receive enable low");
  a_first_only: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_data_received_irq && !$past(rx_ctrl) |-> !$past(rx_act))
    else $error("later byte flagged without receive control");
  a_double_look: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    acc |-> rx_w.mon == prev_mon && !prev_mx)
    else $error("byte accepted without two equal frames");
  sequence s_rx_fault;
    fd && mx_fall && pend;
  endsequence
  a_slave_abort: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_rx_fault |=> ab_cnt == mcih_pkg::END_FRAMES && mr_out && !rx_act)
    else $error("receive fault did not hold handshake inactive");
  a_master_mr: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !slave && !i_rx_handshake_ctrl |-> tx_w.mr)
    else $error("receive handshake active without software control");

  //////////////////////////////////////////////////////////////////////////////
  // slave command decoding and reply generation
  mcih_pkg::mcih_cmd_e cmd;
  logic hdr_wr;
  logic hdr_rd;
  logic [1:0] rep_cnt;
  logic rep_id;
  logic fifo_in_ready;
  logic fifo_ov;
  logic [7:0] fifo_od;
  logic pop;
  wire sacc = acc && slave;
  wire [7:0] b = rx_w.mon;
  wire is_wr_hdr = b == mcih_pkg::HDR_WR_A || b == mcih_pkg::HDR_WR_B;
  wire is_rd_hdr = b == mcih_pkg::HDR_RD_A || b == mcih_pkg::HDR_RD_B;
  wire rep_v = rep_cnt != 2'h0;
  wire [7:0] rep_b = (rep_cnt == mcih_pkg::REPLY_BYTES) ?
                     (rep_id ? mcih_pkg::IDENT_ADDR_BYTE : mcih_pkg::READ_REPLY_ADDR) :
                     (rep_id ? {mcih_pkg::IDENT_PREFIX, DESIGN_CODE} : i_reg_rdata);
  wire in_v = slave ? rep_v : i_tx_valid;
  wire [7:0] in_d = slave ? rep_b : i_tx_data;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cmd <= mcih_pkg::CMD_NONE;
      hdr_wr <= 1'b0;
      hdr_rd <= 1'b0;
      rep_cnt <= 2'h0;
      rep_id <= 1'b0;
      o_reg_wr <= 1'b0;
      o_reg_addr <= 7'h00;
      o_reg_wdata <= 8'h00;
    end
    else
    begin
      o_reg_wr <= sacc && rx_idx == mcih_pkg::IDX_DATA && cmd == mcih_pkg::CMD_PROG
                  && hdr_wr && !hdr_rd;
      if (o_reg_wr)
        o_reg_addr <= o_reg_addr + 7'h01;
      if (rep_v && fifo_in_ready)
        rep_cnt <= rep_cnt - 2'h1;
      if (sacc)
        case (rx_idx)
          3'h0:
          begin
            cmd <= (b[7:4] != mcih_pkg::SLAVE_ADDR_NIB) ? mcih_pkg::CMD_NONE :
                   (b[3:0] == mcih_pkg::CMD_IDENT_NIB) ? mcih_pkg::CMD_IDENT :
                   (b[3:0] == mcih_pkg::CMD_PROG_NIB) ? mcih_pkg::CMD_PROG : mcih_pkg::CMD_NONE;
            hdr_wr <= 1'b0;
            hdr_rd <= 1'b0;
          end
          3'h1:
          begin
            if (cmd == mcih_pkg::CMD_IDENT)
            begin
              rep_cnt <= mcih_pkg::REPLY_BYTES;
              rep_id <= 1'b1;
            end
            hdr_wr <= is_wr_hdr;
            hdr_rd <= is_rd_hdr;
          end
          3'h2:
          begin
            o_reg_addr <= b[6:0];
            if (cmd == mcih_pkg::CMD_PROG && (hdr_rd || b[7]))
            begin
              hdr_rd <= 1'b1;
              rep_cnt <= mcih_pkg::REPLY_BYTES;
              rep_id <= 1'b0;
            end
          end
          default:
            o_reg_wdata <= b;
        endcase
    end
  end

  a_ident_reply: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    sacc && rx_idx == 3'h1 && cmd == mcih_pkg::CMD_IDENT
    |=> rep_cnt == mcih_pkg::REPLY_BYTES && rep_id)
    else $error("identification request not answered");

  mcih_fifo #(.WIDTH(mcih_pkg::BYTE_W), .DEPTH(mcih_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_in_valid(in_v),
    .i_in_data(in_d),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_ov),
    .o_out_data(fifo_od),
    .i_out_ready(pop)
  );
  assign o_tx_ready = fifo_in_ready;

  //////////////////////////////////////////////////////////////////////////////
  // transmit side of the control channel
  mcih_pkg::mcih_tx_e tx_state;
  mcih_pkg::mcih_tx_e next_tx_state;
  logic [7:0] tx_byte;
  logic acked;
  logic mr_seen;
  logic prev_mr;
  logic [TW-1:0] tmr;
  wire tx_more = slave ? (fifo_ov || rep_v) : i_tx_handshake_ctrl;
  wire busy = tx_state == mcih_pkg::TX_SEND || tx_state == mcih_pkg::TX_GAP;
  wire tmr_run = tx_state == mcih_pkg::TX_SEND && !acked;
  wire tmr_exp = tmr == TMR_LAST;
  wire ack = tx_state == mcih_pkg::TX_SEND && !acked && !rx_w.mr && (!mr_seen || prev_mr);
  wire mr_abort = busy && mr_seen && rx_w.mr && prev_mr;
  wire mr_err = tx_state == mcih_pkg::TX_GAP && prev_mr && !rx_w.mr;
  wire tmo = tmr_run && tmr_exp && i_reply_timeout_enable;
  wire tx_abort = fd && busy && (mr_abort || mr_err || coll || tmo);
  wire start = tx_state == mcih_pkg::TX_IDLE && tx_more && fifo_ov;
  wire next_byte = tx_state == mcih_pkg::TX_SEND && acked && !tx_abort && fifo_ov && tx_more;
  assign pop = fd && (start || next_byte);

  always_comb
  begin
    next_tx_state = tx_state;
    case (tx_state)
      mcih_pkg::TX_IDLE:
        if (start)
          next_tx_state = mcih_pkg::TX_SEND;
      mcih_pkg::TX_SEND:
        if (tx_abort || (acked && !tx_more))
          next_tx_state = mcih_pkg::TX_EOM1;
        else if (next_byte)
          next_tx_state = mcih_pkg::TX_GAP;
      mcih_pkg::TX_GAP:
        next_tx_state = tx_abort ? mcih_pkg::TX_EOM1 : mcih_pkg::TX_SEND;
      mcih_pkg::TX_EOM1:
        next_tx_state = mcih_pkg::TX_EOM2;
      default:
        next_tx_state = mcih_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tx_state <= mcih_pkg::TX_IDLE;
      tx_byte <= 8'hFF;
      acked <= 1'b0;
      mr_seen <= 1'b0;
      prev_mr <= 1'b1;
    end
    else if (fd)
    begin
      tx_state <= next_tx_state;
      prev_mr <= rx_w.mr;
      if (pop)
        tx_byte <= fifo_od;
      acked <= (next_tx_state == mcih_pkg::TX_SEND) && (acked || ack) && !pop;
      mr_seen <= start ? 1'b0 : (busy && !rx_w.mr) ? 1'b1 : mr_seen;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      tmr <= '0;
    else if (!tmr_run || (fd && ack))
      tmr <= '0;
    else if (!tmr_exp)
      tmr <= tmr + 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_data_acked_irq <= 1'b0;
      o_transfer_abort_irq <= 1'b0;
      o_tx_active_flag <= 1'b0;
    end
    else
    begin
      o_data_acked_irq <= fd && ack && !tx_abort && i_ctl_chan_irq_enable;
      o_transfer_abort_irq <= tx_abort && i_ctl_chan_irq_enable;
      o_tx_active_flag <= next_tx_state != mcih_pkg::TX_IDLE || tx_state != mcih_pkg::TX_IDLE;
    end
  end

  assign tx_w.mon = tx_byte;
  assign tx_w.l1 = i_l1_code_tx;
  assign tx_w.mr = mr_out;
  assign tx_w.mx = tx_state != mcih_pkg::TX_SEND;
  assign tx_w.aux = i_aux_code_width_sel ? i_aux_code_tx :
                    {mcih_pkg::AUX_PAD, i_aux_code_tx[3:0]};
  assign drive_mask = mcih_pkg::DRIVE_FIXED_MASK |
                      ((tx_state != mcih_pkg::TX_IDLE) ? mcih_pkg::DRIVE_MON_MASK : 20'h00000);

  sequence s_tx_fault;
    fd && busy && (coll || mr_abort || mr_err);
  endsequence
  a_tx_fault_end: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_tx_fault |=> tx_state == mcih_pkg::TX_EOM1 && tx_w.mx)
    else $error("transmit fault did not start end of message");
  a_timeout_end: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    fd && busy && tmo |=> tx_state == mcih_pkg::TX_EOM1 ##1 tx_w.mx)
    else $error("reply timeout did not abort");
  a_shared_enable: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_end_of_reception_irq || o_data_acked_irq || o_transfer_abort_irq
    |-> $past(i_ctl_chan_irq_enable))
    else $error("channel status raised with shared enable low");
  a_timer_restart: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    fd && ack |=> tmr == '0)
    else $error("reply timer not restarted on acknowledge");

  //////////////////////////////////////////////////////////////////////////////
  // command/indication channels
  logic [3:0] l1_last;
  wire [5:0] aux_mask = i_aux_code_width_sel ? 6'h3F : 6'h0F;
  wire l1_new = fd && rx_w.l1 == l1_last && rx_w.l1 != o_l1_code_rx;
  wire aux_new = fd && ((rx_w.aux ^ o_aux_code_rx) & aux_mask) != 6'h00;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      l1_last <= 4'hF;
      o_l1_code_rx <= 4'hF;
      o_aux_code_rx <= 6'h3F;
      o_code_change_irq <= 1'b0;
      o_aux_change_irq <= 1'b0;
    end
    else
    begin
      if (fd)
      begin
        l1_last <= rx_w.l1;
        o_aux_code_rx <= rx_w.aux;
      end
      if (l1_new)
        o_l1_code_rx <= rx_w.l1;
      o_code_change_irq <= l1_new;
      o_aux_change_irq <= aux_new;
    end
  end

  a_l1_two_frames: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_code_change_irq |-> $past(fd) && $past(rx_w.l1) == $past(l1_last))
    else $error("layer-1 code change without two equal frames");
  a_aux_masked: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_aux_change_irq
    |-> (($past(rx_w.aux) ^ $past(o_aux_code_rx)) & $past(aux_mask)) != 6'h00)
    else $error("aux change flagged on ignored bits");
endmodule

/* tb/mcih_partner.sv */
`timescale 1ns/1ps
module mcih_partner (
  // frame to send
  input wire mcih_pkg::mcih_frame_s i_frame,
  // bus pins and frame count
  output logic o_bit_clk,
  output logic o_fsync,
  output logic o_dd,
  output int o_frames
);
  logic [4:0] pos = 5'h17;
  logic [19:0] cur = 20'hFFFFF;
  initial
  begin
    o_bit_clk = 1'b0;
    o_fsync = 1'b0;
    o_dd = 1'b1;
    o_frames = 0;
    #37;
    forever #100 o_bit_clk = ~o_bit_clk;
  end
  // new bits on the falling edge, idle slots pulled high
  always @(negedge o_bit_clk)
  begin
    pos = (pos == mcih_pkg::LAST_FRAME_POS) ? 5'h00 : pos + 5'h01;
    if (pos == 5'h00)
    begin
      cur = i_frame;
      o_frames = o_frames + 1;
    end
    o_fsync = (pos == 5'h00);
    o_dd = (pos <= mcih_pkg::LAST_DATA_POS) ? cur[5'h13 - pos] : 1'b1;
  end
endmodule

/* tb/mcih_top_tb_top.sv */
`timescale 1ns/1ps
module mcih_top_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tx_v = 1'b0;
  logic [7:0] tx_d = 8'h00;
  logic txc = 1'b0, ctl_chan_irq_enable = 1'b1, rx_irq_enable = 1'b1, toe = 1'b0, wsel = 1'b0, rx_handshake_ctrl = 1'b0;
  logic bclk, fs, dd, du, du_oe, rdy, act, dr, er, ack, ab, c_l1, c_aux;
  logic [7:0] rx_b;
  logic [3:0] l1;
  logic [5:0] aux;
  mcih_pkg::mcih_frame_s fr = 20'hFFFFF;
  int frames, errors = 0, tests_run = 0;
  int n_dr = 0, n_er = 0, n_ack = 0, n_ab = 0, n_l1 = 0, n_aux = 0;
  always #12.5 clk = ~clk;
  mcih_partner i_mcih_partner (.i_frame(fr), .o_bit_clk(bclk), .o_fsync(fs), .o_dd(dd),
    .o_frames(frames));
  mcih_top #(.REPLY_TIMEOUT_CYC(400)) i_mcih_top (.i_clk_sys(clk), .i_resetn(rstn),
    .i_bit_clk(bclk), .i_fsync(fs), .i_dd(dd), .i_du(du_oe ? du : 1'b1), .o_du(du),
    .o_du_oe(du_oe), .i_slave_strap(1'b0), .o_slave_mode(), .i_tx_valid(tx_v),
    .i_tx_data(tx_d), .o_tx_ready(rdy), .i_tx_handshake_ctrl(txc), .i_rx_handshake_ctrl(rx_handshake_ctrl),
    .i_ctl_chan_irq_enable(ctl_chan_irq_enable), .i_rx_irq_enable(rx_irq_enable), .i_reply_timeout_enable(toe),
    .o_ctl_chan_rx_byte(rx_b), .o_data_received_irq(dr), .o_end_of_reception_irq(er),
    .o_data_acked_irq(ack), .o_transfer_abort_irq(ab), .o_tx_active_flag(act),
    .i_l1_code_tx(4'hF), .i_aux_code_tx(6'h3F), .i_aux_code_width_sel(wsel),
    .o_l1_code_rx(l1), .o_aux_code_rx(aux), .o_code_change_irq(c_l1),
    .o_aux_change_irq(c_aux), .o_reg_wr(), .o_reg_addr(), .o_reg_wdata(), .i_reg_rdata(8'h00));
  always @(posedge clk)
  begin
    n_dr <= n_dr + int'(dr === 1'b1);
    n_er <= n_er + int'(er === 1'b1);
    n_ack <= n_ack + int'(ack === 1'b1);
    n_ab <= n_ab + int'(ab === 1'b1);
    n_l1 <= n_l1 + int'(c_l1 === 1'b1);
    n_aux <= n_aux + int'(c_aux === 1'b1);
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic fw(input int n);
    repeat (n) @(frames);
    @(posedge clk);
    #2;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_l1();
    chk("reset oe", {7'h00, du_oe}, 8'h00);
    chk("reset l1", {4'h0, l1}, 8'h0F);
    fr.l1 = 4'h5;
    fw(3);
    fr.l1 = 4'h9;
    fw(1);
    fr.l1 = 4'h5;
    fw(3);
    chk("l1 code", {4'h0, l1}, 8'h05);
    chk("l1 irqs", 8'(n_l1), 8'h01);
    $display("test l1 done");
  endtask
  task automatic t_aux();
    fr.aux = 6'h0F;
    fw(3);
    chk("aux top ignored", 8'(n_aux), 8'h00);
    fr.aux = 6'h0E;
    fw(2);
    chk("aux raw", {2'h0, aux}, 8'h0E);
    chk("aux irq", 8'(n_aux), 8'h01);
    wsel = 1'b1;
    fr.aux = 6'h2E;
    fw(2);
    chk("aux wide", 8'(n_aux), 8'h02);
    $display("test aux done");
  endtask
  task automatic t_rx();
    fr.mon = 8'h5A;
    fr.mx = 1'b0;
    fw(1);
    fr.mon = 8'hA5;
    fw(3);
    fr.mx = 1'b1;
    fw(3);
    chk("rx byte", rx_b, 8'hA5);
    chk("rx irq", 8'(n_dr), 8'h01);
    chk("rx end", 8'(n_er), 8'h01);
    rx_irq_enable = 1'b0;
    fr.mon = 8'h3C;
    fr.mx = 1'b0;
    fw(3);
    fr.mx = 1'b1;
    fw(3);
    chk("rx masked", 8'(n_dr), 8'h01);
    $display("test rx done");
  endtask
  task automatic t_tx();
    tx_v = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      tx_d = 8'h10 + 8'(i);
      @(posedge clk);
      #2;
    end
    tx_v = 1'b0;
    chk("fifo full", {7'h00, rdy}, 8'h00);
    txc = 1'b1;
    fw(2);
    repeat (4)
    begin
      fr.mr = 1'b1;
      fw(1);
      fr.mr = 1'b0;
      fw(2);
    end
    chk("acks", 8'(n_ack), 8'h04);
    chk("fifo drained", {7'h00, rdy}, 8'h01);
    txc = 1'b0;
    fw(3);
    fr.mr = 1'b1;
    fw(3);
    chk("tx idle", {7'h00, act}, 8'h00);
    chk("no abort", 8'(n_ab), 8'h00);
    $display("test tx done");
  endtask
  task automatic t_reply_timeout_enable();
    toe = 1'b1;
    tx_v = 1'b1;
    tx_d = 8'h77;
    @(posedge clk);
    #2;
    tx_v = 1'b0;
    txc = 1'b1;
    fw(5);
    txc = 1'b0;
    fw(3);
    chk("timeout abort", 8'(n_ab), 8'h01);
    $display("test timeout done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #2;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    t_l1();
    t_aux();
    t_rx();
    t_tx();
    t_reply_timeout_enable();
    summarize();
  end
  initial
  begin
    #1000000;
    errors++;
    summarize();
  end
endmodule
